// ---- hw/sadc_pkg.sv ----
// Purpose: shared constants and types for the converter control block
// Assumes: 8-bit register port, one system clock
// Notes: register offsets are local choices
package sadc_pkg;
  localparam logic [2:0] OFS_CTRL_A = 3'h0;
  localparam logic [2:0] OFS_CTRL_B = 3'h1;
  localparam logic [2:0] OFS_RES_LO = 3'h2;
  localparam logic [2:0] OFS_RES_HI = 3'h3;
  localparam logic [2:0] OFS_IRQ_STAT = 3'h4;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h5;
  localparam logic [2:0] OFS_SETTLE = 3'h6;
  localparam int BIT_START = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_EN = 5;
  localparam int BIT_JUST = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SETTLE_RST = 8'h10;
  localparam logic [4:0] SAMPLE_PERIODS = 5'h04;
  localparam logic [4:0] CONV_PERIODS = 5'h10;
  localparam int RES_W = 12;
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_BANDGAP = 2'h1;
  localparam logic [1:0] SRC_GND = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_READY = 2'b10,
    ST_CONV = 2'b11
  } sadc_state_t;
  typedef struct packed {
    logic [1:0] source;
    logic [3:0] channel;
    logic ext_sel;
    logic ref_ext;
    logic sample;
  } sadc_analog_t;
endpackage

// ---- hw/sadc_ctrl.sv ----
// Purpose: control and result registers around a 12-bit SAR converter core
// Assumes: core returns one serial result bit per conversion clock during conversion
// Notes: one conversion clock tick per divided period
// Notes on behaviour
// - each conversion yields a twelve-bit result, external or internal source
// - justify 0: high byte D11..D4, low byte D3..D0 in upper nibble
// - justify 1: low byte D7..D0, high byte D11..D8 in lower nibble
// - while disabled both result bytes keep their contents
// - a conversion starts only on start bit written high then low
// - busy flag set once a conversion is initiated
// - busy cleared at completion, new result then readable
// - busy flag is read only
// - channel codes 0..11 select an input, 11xx selects none
// - source 001 bandgap, 010..100 ground, others external channel
// - reference code 01 is analog supply, else external reference pin
// - conversion clock is system clock divided by two to the field
// - a pin used as converter input drops its function and pull-up
// - conversions only while enabled, after a settling delay
// - conversion lasts 16 clock periods: 4 sampling, 12 converting
// - completion sets the converter interrupt flag
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module sadc_ctrl
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic core_bit_i,
  output sadc_pkg::sadc_analog_t analog_o,
  output logic [11:0] pin_analog_o,
  output logic conv_clk_o,
  output logic irq_o
);
  // ==========================================================
  // registers
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] settle_reg;
  logic [7:0] res_lo_reg;
  logic [7:0] res_hi_reg;
  logic [11:0] shift_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic start_seen_reg;
  logic busy_reg;
  logic [6:0] div_reg;
  logic [4:0] period_reg;
  logic [7:0] settle_cnt_reg;
  sadc_pkg::sadc_state_t state_reg;
  logic tick;
  logic start_fall;
  logic done;
  logic aborted;
  logic conv_en;
  logic [2:0] src_field;

  assign conv_en = ctrl_a_reg[sadc_pkg::BIT_EN];
  assign src_field = ctrl_b_reg[7:5];
  // start completes when software clears a bit that it had set
  assign start_fall = wr_i && addr_i == sadc_pkg::OFS_CTRL_A && start_seen_reg
    && !wdata_i[sadc_pkg::BIT_START];
  // a final tick in the cycle that disables counts as an abort, not a completion
  assign done = conv_en && state_reg == sadc_pkg::ST_CONV && tick
    && period_reg == sadc_pkg::CONV_PERIODS - 5'h01;
  assign aborted = !conv_en && state_reg == sadc_pkg::ST_CONV;

  // ==========================================================
  // conversion clock divider
  function automatic logic div_hit(input logic [6:0] cnt, input logic [2:0] sel);
    logic [7:0] lim;
    lim = (8'h01 << sel) - 8'h01;
    return {1'b0, cnt} >= lim;
  endfunction

  assign tick = div_hit(div_reg, ctrl_b_reg[2:0]);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || tick || !conv_en)
      div_reg <= 7'h00;
    else
      div_reg <= div_reg + 7'h01;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      conv_clk_o <= 1'b0;
    else
      conv_clk_o <= conv_en && tick && state_reg == sadc_pkg::ST_CONV;
  end

  // ==========================================================
  // control registers
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_a_reg <= sadc_pkg::CTRL_RST;
      ctrl_b_reg <= sadc_pkg::CTRL_RST;
      settle_reg <= sadc_pkg::SETTLE_RST;
      irq_mask_reg <= 2'h0;
    end
    else if (wr_i)
    begin
      if (addr_i == sadc_pkg::OFS_CTRL_A)
      begin
        ctrl_a_reg[7] <= wdata_i[7];
        ctrl_a_reg[5:0] <= wdata_i[5:0];
      end
      if (addr_i == sadc_pkg::OFS_CTRL_B)
        ctrl_b_reg <= wdata_i;
      if (addr_i == sadc_pkg::OFS_SETTLE)
        settle_reg <= wdata_i;
      if (addr_i == sadc_pkg::OFS_IRQ_MASK)
        irq_mask_reg <= wdata_i[1:0];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      start_seen_reg <= 1'b0;
    else if (wr_i && addr_i == sadc_pkg::OFS_CTRL_A)
      start_seen_reg <= wdata_i[sadc_pkg::BIT_START];
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !conv_en)
    begin
      state_reg <= sadc_pkg::ST_IDLE;
      settle_cnt_reg <= 8'h00;
      period_reg <= 5'h00;
    end
    else
    begin
      case (state_reg)
        sadc_pkg::ST_IDLE:
        begin
          settle_cnt_reg <= 8'h00;
          state_reg <= sadc_pkg::ST_SETTLE;
        end
        sadc_pkg::ST_SETTLE:
        begin
          settle_cnt_reg <= settle_cnt_reg + 8'h01;
          if (settle_cnt_reg >= settle_reg)
            state_reg <= sadc_pkg::ST_READY;
        end
        sadc_pkg::ST_READY:
        begin
          // starts during settling are dropped; starts while busy too
          if (start_fall)
          begin
            period_reg <= 5'h00;
            state_reg <= sadc_pkg::ST_CONV;
          end
        end
        sadc_pkg::ST_CONV:
        begin
          if (tick)
            period_reg <= period_reg + 5'h01;
          if (done)
            state_reg <= sadc_pkg::ST_READY;
        end
        default:
          state_reg <= sadc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      busy_reg <= 1'b0;
    else if (state_reg == sadc_pkg::ST_READY && start_fall && conv_en)
      busy_reg <= 1'b1;
    else if (done || aborted)
      busy_reg <= 1'b0;
  end

  // ==========================================================
  // result capture, serial bits MSB first after sampling
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      shift_reg <= 12'h000;
    else if (conv_en && state_reg == sadc_pkg::ST_CONV && tick && period_reg >= sadc_pkg::SAMPLE_PERIODS)
      shift_reg <= {shift_reg[10:0], core_bit_i};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      res_lo_reg <= 8'h00;
      res_hi_reg <= 8'h00;
    end
    else if (conv_en && done)
    begin
      // last bit arrives with the final tick
      if (ctrl_a_reg[sadc_pkg::BIT_JUST])
      begin
        res_hi_reg <= {4'h0, shift_reg[10:7]};
        res_lo_reg <= {shift_reg[6:0], core_bit_i};
      end
      else
      begin
        res_hi_reg <= shift_reg[10:3];
        res_lo_reg <= {shift_reg[2:0], core_bit_i, 4'h0};
      end
    end
  end // no write path while disabled

  // ==========================================================
  // interrupts: bit0 done, bit1 aborted; set beats clear
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      irq_stat_reg <= 2'h0;
    else
      irq_stat_reg <= (irq_stat_reg & ~((wr_i && addr_i == sadc_pkg::OFS_IRQ_STAT) ? wdata_i[1:0] : 2'h0))
        | {aborted, done};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat_reg & irq_mask_reg);
  end

  // ==========================================================
  // analog routing
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      analog_o <= '0;
      pin_analog_o <= 12'h000;
    end
    else
    begin
      case (src_field)
        3'b001: analog_o.source <= sadc_pkg::SRC_BANDGAP;
        3'b010, 3'b011, 3'b100: analog_o.source <= sadc_pkg::SRC_GND;
        default: analog_o.source <= sadc_pkg::SRC_EXT;
      endcase
      analog_o.channel <= ctrl_a_reg[3:0];
      analog_o.ext_sel <= ctrl_a_reg[3:2] != 2'b11;
      analog_o.ref_ext <= ctrl_b_reg[4:3] != 2'b01;
      analog_o.sample <= state_reg == sadc_pkg::ST_CONV && period_reg < sadc_pkg::SAMPLE_PERIODS;
      // pin takeover removes port function and pull-up
      for (int i = 0; i < 12; i++)
        pin_analog_o[i] <= conv_en && ctrl_a_reg[3:0] == 4'(i);
    end
  end

  // ==========================================================
  // register read port
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      case (addr_i)
        sadc_pkg::OFS_CTRL_A: rdata_o <= {ctrl_a_reg[7], busy_reg, ctrl_a_reg[5:0]};
        sadc_pkg::OFS_CTRL_B: rdata_o <= ctrl_b_reg;
        sadc_pkg::OFS_RES_LO: rdata_o <= res_lo_reg;
        sadc_pkg::OFS_RES_HI: rdata_o <= res_hi_reg;
        sadc_pkg::OFS_IRQ_STAT: rdata_o <= {6'h00, irq_stat_reg};
        sadc_pkg::OFS_IRQ_MASK: rdata_o <= {6'h00, irq_mask_reg};
        sadc_pkg::OFS_SETTLE: rdata_o <= settle_reg;
        default: rdata_o <= 8'h00;
      endcase
    else
      rdata_o <= 8'h00;
  end

  // ==========================================================
  // checks
  property p_busy_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == sadc_pkg::ST_READY && start_fall && conv_en) |=> busy_reg;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set after start");

  property p_start_only;
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(busy_reg) |-> $past(start_fall);
  endproperty
  a_start_only: assert property (p_start_only) else $error("busy rose without start sequence");

  property p_sample_open;
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(busy_reg) |=> analog_o.sample;
  endproperty
  a_sample_open: assert property (p_sample_open) else $error("sampling not opened at start");

  property p_busy_clr;
    @(posedge sys_clk_i) disable iff (rst_i)
    done |=> !busy_reg && irq_stat_reg[0];
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy or flag wrong at completion");

  property p_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    !conv_en |=> $stable(res_lo_reg) && $stable(res_hi_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed while disabled");

  property p_just0;
    @(posedge sys_clk_i) disable iff (rst_i)
    !ctrl_a_reg[sadc_pkg::BIT_JUST] && done |=> res_lo_reg[3:0] == 4'h0;
  endproperty
  a_just0: assert property (p_just0) else $error("low nibble not zero");

  property p_just1;
    @(posedge sys_clk_i) disable iff (rst_i)
    ctrl_a_reg[sadc_pkg::BIT_JUST] && done |=> res_hi_reg[7:4] == 4'h0;
  endproperty
  a_just1: assert property (p_just1) else $error("high nibble not zero");

  property p_abort;
    @(posedge sys_clk_i) disable iff (rst_i)
    aborted |=> !busy_reg && state_reg == sadc_pkg::ST_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not clear busy");

  property p_ref;
    @(posedge sys_clk_i) disable iff (rst_i)
    ctrl_b_reg[4:3] == 2'b01 && $stable(ctrl_b_reg) |=> !analog_o.ref_ext;
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");

  property p_irq;
    @(posedge sys_clk_i) disable iff (rst_i)
    (irq_stat_reg & irq_mask_reg) != 2'h0 |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// ---- tb/sadc_core_model.sv ----
// Purpose: behavioural converter core that answers the control block bit by bit
// Assumes: result bits are taken at conversion ticks of periods 4..15, msb first
// Notes: counts ticks and the spacing of the last two for the bench
`timescale 1ns/1ps
module sadc_core_model
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic arm_i,
  input wire logic [11:0] value_i,
  input wire logic conv_clk_i,
  output logic core_bit_o,
  output logic [7:0] n_ticks_o,
  output logic [7:0] gap_o
);
  logic [11:0] value_reg;
  logic [7:0] since_reg;
  logic toggle_reg;
  logic [7:0] idx;
  // a tick visible now is counted one edge late, so look ahead by it
  assign idx = n_ticks_o + {7'h00, conv_clk_i};
  // outside the bit periods the line churns so a stray sample cannot match by luck
  assign core_bit_o = (idx >= 8'h04 && idx <= 8'h0F) ? value_reg[4'(8'h0F - idx)] : toggle_reg;
  always_ff @(posedge sys_clk_i)
  begin
    toggle_reg <= rst_i ? 1'b0 : ~toggle_reg;
    if (rst_i || arm_i)
    begin
      n_ticks_o <= 8'h00;
      since_reg <= 8'h00;
      gap_o <= 8'h00;
      value_reg <= value_i;
    end
    else if (conv_clk_i)
    begin
      n_ticks_o <= n_ticks_o + 8'h01;
      gap_o <= since_reg + 8'h01;
      since_reg <= 8'h00;
    end
    else
    begin
      since_reg <= since_reg + 8'h01;
    end
  end
endmodule

// ---- tb/sadc_ctrl_tb.sv ----
// Purpose: self-checking bench for the converter control block
// Assumes: a mask bit high lets its status bit reach the interrupt
// Notes: settle count shortened to keep the run short
`timescale 1ns/1ps
module sadc_ctrl_tb;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [11:0] val;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [1:0] src;
    logic ext;
    logic rfx;
  } sadc_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic core_bit;
  sadc_pkg::sadc_analog_t analog;
  logic [11:0] pins;
  logic conv_clk;
  logic irq;
  logic arm = 1'b0;
  logic [11:0] value = 12'h000;
  logic [7:0] n_ticks;
  logic [7:0] gap;
  logic [7:0] v;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  sadc_row_t r;
  // internal sources always carry channel 11xx
  sadc_row_t rows [8] = '{
    '{8'h20, 8'h00, 12'hABC, 8'hC0, 8'hAB, 2'h0, 1'b1, 1'b1},
    '{8'h3C, 8'h29, 12'h5A3, 8'hA3, 8'h05, 2'h1, 1'b0, 1'b0},
    '{8'h2D, 8'h52, 12'h001, 8'h10, 8'h00, 2'h2, 1'b0, 1'b1},
    '{8'h3E, 8'h7B, 12'hFFF, 8'hFF, 8'h0F, 2'h2, 1'b0, 1'b1},
    '{8'h2F, 8'h84, 12'h800, 8'h00, 8'h80, 2'h2, 1'b0, 1'b1},
    '{8'h3B, 8'hAD, 12'h7FE, 8'hFE, 8'h07, 2'h0, 1'b1, 1'b0},
    '{8'h25, 8'hD6, 12'h321, 8'h10, 8'h32, 2'h0, 1'b1, 1'b1},
    '{8'h2C, 8'hEF, 12'h9D7, 8'h70, 8'h9D, 2'h0, 1'b0, 1'b0}};
  always #4 sys_clk = ~sys_clk;
  sadc_ctrl dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .core_bit_i(core_bit), .analog_o(analog), .pin_analog_o(pins), .conv_clk_o(conv_clk),
    .irq_o(irq));
  sadc_core_model core_u (.sys_clk_i(sys_clk), .rst_i(rst), .arm_i(arm), .value_i(value), .conv_clk_i(conv_clk),
    .core_bit_o(core_bit), .n_ticks_o(n_ticks), .gap_o(gap));
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic start(input logic [7:0] a);
    wr_reg(sadc_pkg::OFS_CTRL_A, a | 8'h80);
    wr_reg(sadc_pkg::OFS_CTRL_A, a);
  endtask
  task automatic arm_core(input logic [11:0] x);
    @(posedge sys_clk);
    arm <= 1'b1;
    value <= x;
    @(posedge sys_clk);
    arm <= 1'b0;
  endtask
  task automatic wait_idle();
    logic [7:0] s;
    s = 8'h40;
    for (int k = 0; k < 3000 && s[6] !== 1'b0; k++)
      rd_reg(sadc_pkg::OFS_CTRL_A, s);
    chk("busy_end", 12'h000, 12'(s[6]));
  endtask
  // hang guard, well above the slowest divider pass
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      conclude();
    end
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    wr_reg(sadc_pkg::OFS_SETTLE, 8'h02);
    wr_reg(sadc_pkg::OFS_IRQ_MASK, 8'h03);
    foreach (rows[i])
    begin
      r = rows[i];
      wr_reg(sadc_pkg::OFS_CTRL_B, r.b);
      wr_reg(sadc_pkg::OFS_CTRL_A, r.a);
      repeat (6) @(posedge sys_clk);
      arm_core(r.val);
      start(r.a);
      rd_reg(sadc_pkg::OFS_CTRL_A, v);
      chk("busy", 12'h001, 12'(v[6]));
      wait_idle();
      chk("ticks", 12'h010, 12'(n_ticks));
      chk("gap", 12'h001 << r.b[2:0], 12'(gap));
      rd_reg(sadc_pkg::OFS_RES_LO, v);
      chk("res_lo", 12'(r.lo), 12'(v));
      rd_reg(sadc_pkg::OFS_RES_HI, v);
      chk("res_hi", 12'(r.hi), 12'(v));
      chk("source", 12'(r.src), 12'(analog.source));
      chk("channel", 12'(r.a[3:0]), 12'(analog.channel));
      chk("ext_sel", 12'(r.ext), 12'(analog.ext_sel));
      chk("ref_ext", 12'(r.rfx), 12'(analog.ref_ext));
      chk("pins", r.ext ? 12'h001 << r.a[3:0] : 12'h000, pins);
      rd_reg(sadc_pkg::OFS_IRQ_STAT, v);
      chk("irq_stat", 12'h001, 12'(v));
      chk("irq", 12'h001, 12'(irq));
      wr_reg(sadc_pkg::OFS_IRQ_MASK, 8'h00);
      @(posedge sys_clk);
      #1 chk("irq_masked", 12'h000, 12'(irq));
      wr_reg(sadc_pkg::OFS_IRQ_MASK, 8'h03);
      wr_reg(sadc_pkg::OFS_IRQ_STAT, 8'h03);
      @(posedge sys_clk);
      #1 chk("irq_clear", 12'h000, 12'(irq));
    end
    // start held high alone must not launch; busy bit ignores writes
    wr_reg(sadc_pkg::OFS_CTRL_A, 8'hE5);
    rd_reg(sadc_pkg::OFS_CTRL_A, v);
    chk("ctrl_a", 12'h0A5, 12'(v));
    // only the slowest divider keeps the rate in the recommended band
    wr_reg(sadc_pkg::OFS_CTRL_B, 8'hEF);
    arm_core(12'h123);
    wr_reg(sadc_pkg::OFS_CTRL_A, 8'h25);
    start(8'h25);
    rd_reg(sadc_pkg::OFS_CTRL_A, v);
    chk("busy", 12'h001, 12'(v[6]));
    chk("sampling", 12'h001, 12'(analog.sample));
    wr_reg(sadc_pkg::OFS_CTRL_A, 8'h05);
    rd_reg(sadc_pkg::OFS_CTRL_A, v);
    chk("abort_busy", 12'h005, 12'(v));
    chk("sample_off", 12'h000, 12'(analog.sample));
    rd_reg(sadc_pkg::OFS_RES_LO, v);
    chk("res_lo", 12'h070, 12'(v));
    rd_reg(sadc_pkg::OFS_RES_HI, v);
    chk("res_hi", 12'h09D, 12'(v));
    rd_reg(sadc_pkg::OFS_IRQ_STAT, v);
    chk("irq_stat", 12'h002, 12'(v));
    chk("irq_abort", 12'h001, 12'(irq));
    start(8'h05);
    rd_reg(sadc_pkg::OFS_CTRL_A, v);
    chk("off_start", 12'h005, 12'(v));
    rd_reg(3'h7, v);
    chk("unmapped", 12'h000, 12'(v));
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk("analog_rst", 12'h000, 12'(analog));
    chk("irq_rst", 12'h000, 12'(irq));
    rd_reg(sadc_pkg::OFS_CTRL_A, v);
    chk("ctrl_a_rst", 12'(sadc_pkg::CTRL_RST), 12'(v));
    rd_reg(sadc_pkg::OFS_CTRL_B, v);
    chk("ctrl_b_rst", 12'(sadc_pkg::CTRL_RST), 12'(v));
    rd_reg(sadc_pkg::OFS_SETTLE, v);
    chk("settle_rst", 12'(sadc_pkg::SETTLE_RST), 12'(v));
    conclude();
  end
endmodule
